// ---- include/lrc_pkg.sv ----
// lrc_pkg: register map, field positions and reset values of the ladder
// reference control block. assumes a classic wishbone bus with 32-bit data.
package lrc_pkg;
  // register byte offsets
  localparam logic [7:0] LRC_SHARED_OFS = 8'h00;
  localparam logic [7:0] LRC_WDOG_OFS = 8'h04;
  localparam logic [7:0] LRC_STATUS_OFS = 8'h08;
  // ladder_reference_control field positions
  localparam int LRC_POWER_BIT = 7;
  localparam int LRC_PIN_OE_BIT = 6;
  localparam int LRC_RANGE_BIT = 5;
  localparam int LRC_SOURCE_BIT = 4;
  localparam int LRC_TAP_LSB = 0;
  localparam int LRC_TAP_W = 4;
  // watchdog_control field position
  localparam int LRC_ALT_MAP_BIT = 4;
  // status field positions
  localparam int LRC_STAT_DIR_BIT = 0;
  localparam int LRC_STAT_ALT_BIT = 1;
  // reset values
  localparam logic [7:0] LRC_CTRL_RST = 8'h00;
  localparam logic [7:0] LRC_PERIOD_RST = 8'hff;
  localparam logic [7:0] LRC_WDOG_RST = 8'h00;
  localparam logic LRC_DIR_RST = 1'b1;
  localparam logic [31:0] LRC_RDATA_RST = 32'h0000_0000;
  // clk_i cycles software allows the ladder to settle after a change
  localparam int LRC_SETTLE_CYCLES = 8;
  // clk_i cycles of idle that stand in for a sleep period
  localparam int LRC_SLEEP_CYCLES = 64;
endpackage : lrc_pkg

// ---- logic/lrc_ladder_reference_control.sv ----
// lrc_ladder_reference_control: control register of the resistor ladder
// reference, the timer 4 period register it shares an address with, and the
// alternate-map select. assumes port_f_direction_i comes from port logic on clk_i.
//
// Summary of operation
// - bit 7 of the control register powers the ladder on (1) or down (0).
// - bit 6 connects the reference level to port F pin 5 when set.
// - bit 5 selects low range (one) or high range (zero) of the ladder.
// - bit 4 selects external reference pins (one) or analog supply rails (zero).
// - low four bits drive the ladder as an unsigned tap code 0 to 15.
// - while bit 6 is set, port F bit 5 direction is overridden.
// - control register shares the timer 4 period address; alternate-map bit selects it.
// - register contents survive wake-up from sleep; only device reset clears them.
// - device reset clears power, pin enable, range and tap-code bits.
`timescale 1ns/1ps
module lrc_ladder_reference_control
  import lrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // port F pin 5 direction from the port logic, and the value the pin really uses
  input wire logic port_f_direction_i,
  output logic port_f_pin5_direction_o,
  // analog ladder controls
  output logic ladder_power_on_o,
  output logic reference_pin_output_enable_o,
  output logic range_select_o,
  output logic supply_source_select_o,
  output logic [3:0] tap_code_o,
  // period seen by timer 4
  output logic [7:0] timer4_period_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state and decode nets

  logic ack_ff;
  logic nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] period_ff;
  logic [7:0] nxt_period;
  logic [7:0] wdog_ff;
  logic [7:0] nxt_wdog;
  logic dir_ff;
  logic nxt_dir;
  logic req_new;
  logic wr_commit;
  logic alt_map;
  logic hit_shared;
  logic hit_wdog;
  logic hit_status;
  logic hit_ctrl;
  logic hit_period;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // the shared offset has two owners; the alternate-map bit picks one, so a
  // timer driver that never sets it cannot disturb the ladder by accident.
  // unmapped offsets are still acked, read zero and drop writes

  always_comb begin
    hit_shared = 1'b0;
    hit_wdog = 1'b0;
    hit_status = 1'b0;
    if (adr_i == LRC_SHARED_OFS) begin
      hit_shared = 1'b1;
    end else if (adr_i == LRC_WDOG_OFS) begin
      hit_wdog = 1'b1;
    end else if (adr_i == LRC_STATUS_OFS) begin
      hit_status = 1'b1;
    end
  end

  assign alt_map = wdog_ff[LRC_ALT_MAP_BIT];
  assign hit_ctrl = hit_shared & alt_map;
  assign hit_period = hit_shared & ~alt_map;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake
  // ack follows one cycle after the request is taken; read data is latched on
  // the taking edge so dat_o is valid in the same cycle as ack

  assign req_new = cyc_i & stb_i & ~ack_ff;
  // a write lands on the edge where the master samples ack, never earlier;
  // only byte lane 0 carries register bits
  assign wr_commit = cyc_i & stb_i & we_i & ack_ff & sel_i[0];

  always_comb begin
    nxt_ack = req_new;
    nxt_dat = dat_ff;
    if (req_new) begin
      nxt_dat = LRC_RDATA_RST;
      if (hit_ctrl) begin
        nxt_dat[7:0] = ctrl_ff;
      end else if (hit_period) begin
        nxt_dat[7:0] = period_ff;
      end else if (hit_wdog) begin
        nxt_dat[7:0] = wdog_ff;
      end else if (hit_status) begin
        nxt_dat[LRC_STAT_DIR_BIT] = dir_ff;
        nxt_dat[LRC_STAT_ALT_BIT] = alt_map;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= LRC_RDATA_RST;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ladder control register

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_commit && hit_ctrl) begin
      nxt_ctrl = dat_i[7:0];
    end
  end

  // only rst_i clears it; sleep and wake have no path here, so a wake-up
  // finds the ladder exactly as software left it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= LRC_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer 4 period register

  always_comb begin
    nxt_period = period_ff;
    if (wr_commit && hit_period) begin
      nxt_period = dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_ff <= LRC_PERIOD_RST;
    end else begin
      period_ff <= nxt_period;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog control: only the alternate-map select is kept here

  always_comb begin
    nxt_wdog = wdog_ff;
    if (wr_commit && hit_wdog) begin
      nxt_wdog = LRC_WDOG_RST;
      nxt_wdog[LRC_ALT_MAP_BIT] = dat_i[LRC_ALT_MAP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_ff <= LRC_WDOG_RST;
    end else begin
      wdog_ff <= nxt_wdog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin direction override
  // the override must see the new enable in the same cycle the ladder does,
  // so it is computed from the next control value, not the stored one;
  // forcing input keeps a digital driver from fighting the analog level

  always_comb begin
    if (nxt_ctrl[LRC_PIN_OE_BIT]) begin
      nxt_dir = 1'b1;
    end else begin
      nxt_dir = port_f_direction_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_ff <= LRC_DIR_RST;
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // every output is a flop or a slice of one, so the analog side never sees
  // decode glitches

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign port_f_pin5_direction_o = dir_ff;
  assign ladder_power_on_o = ctrl_ff[LRC_POWER_BIT];
  assign reference_pin_output_enable_o = ctrl_ff[LRC_PIN_OE_BIT];
  assign range_select_o = ctrl_ff[LRC_RANGE_BIT];
  assign supply_source_select_o = ctrl_ff[LRC_SOURCE_BIT];
  assign tap_code_o = ctrl_ff[LRC_TAP_LSB +: LRC_TAP_W];
  assign timer4_period_o = period_ff;

endmodule : lrc_ladder_reference_control

// ---- test/lrc_ladder_model.sv ----
// ladder model: level in 1/96 of supply from the control outputs
// assumes the controls are registered on the design clock
`timescale 1ns/1ps
module lrc_ladder_model (
  input wire logic power_i,
  input wire logic range_i,
  input wire logic [3:0] tap_i,
  output logic [6:0] level_o
);
  // powered down gives 0, never a stale level
  assign level_o = !power_i ? 7'h00 : range_i ? 7'(tap_i) * 7'h04
    : 7'h18 + 7'(tap_i) * 7'h03;
endmodule : lrc_ladder_model

// ---- test/lrc_monitor.sv ----
// checker on the ladder control ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module lrc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic port_f_direction_i,
  input wire logic ack_o,
  input wire logic port_f_pin5_direction_o,
  input wire logic ladder_power_on_o,
  input wire logic reference_pin_output_enable_o,
  input wire logic range_select_o,
  input wire logic [3:0] tap_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr = ack_o && we_i;
  wire oe = reference_pin_output_enable_o;
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; ack_o |=> !ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_pwr; $changed(ladder_power_on_o) |-> $past(wr) || $past(rst_i); endproperty
  a_pwr: assert property (p_pwr) else $error("power moved");
  property p_rng; $changed(range_select_o) |-> $past(wr) || $past(rst_i); endproperty
  a_rng: assert property (p_rng) else $error("range moved");
  property p_tap; $changed(tap_code_o) |-> $past(wr) || $past(rst_i); endproperty
  a_tap: assert property (p_tap) else $error("tap moved");
  property p_oe; oe |-> port_f_pin5_direction_o; endproperty
  a_oe: assert property (p_oe) else $error("dir not held");
  // the reset edge is excluded: direction is forced there, not followed
  property p_dir; !oe && !$past(oe) && !$past(rst_i)
    |-> port_f_pin5_direction_o == $past(port_f_direction_i); endproperty
  a_dir: assert property (p_dir) else $error("dir not followed");
  property p_rst; $past(rst_i) |-> !ladder_power_on_o && !oe
    && !range_select_o && tap_code_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
endmodule : lrc_monitor
bind lrc_ladder_reference_control lrc_monitor lrc_monitor_inst (.*);

// ---- test/lrc_ladder_reference_control_tb_top.sv ----
// bench: wishbone register tests of the ladder control
// assumes a 40 MHz clock and the ladder model on the outputs
`timescale 1ns/1ps
module lrc_ladder_reference_control_tb_top import lrc_pkg::*;;
  logic clk_i = '0, rst_i = '1, cyc_i = '0, stb_i = '0, we_i = '0, port_f_direction_i = '0;
  logic [7:0] adr_i = '0, timer4_period_o;
  logic [3:0] sel_i = 4'hf, tap_code_o;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic ack_o, port_f_pin5_direction_o, ladder_power_on_o, reference_pin_output_enable_o;
  logic range_select_o, supply_source_select_o;
  logic [6:0] lvl;
  int miscompares = 0, n_tests = 0;
  wire [7:0] ctl = {ladder_power_on_o, reference_pin_output_enable_o, range_select_o,
    supply_source_select_o, tap_code_o};
  always #12.5 clk_i = ~clk_i;
  lrc_ladder_reference_control lrc_ladder_reference_control_inst (.*);
  lrc_ladder_model lrc_ladder_model_inst (.power_i(ladder_power_on_o),
    .range_i(range_select_o), .tap_i(tap_code_o), .level_o(lvl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    for (int i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    if (ack_o !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask : wb
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, LRC_SHARED_OFS, 32'h0, 4'hf);
    chk(rd, 32'(LRC_PERIOD_RST));
    wb(1'b1, LRC_SHARED_OFS, 32'h12, 4'hf);
    chk(32'(timer4_period_o), 32'h12);
    chk(32'(ctl), 32'h0);
    wb(1'b1, LRC_WDOG_OFS, 32'hff, 4'hf);
    wb(1'b0, LRC_WDOG_OFS, 32'h0, 4'hf);
    chk(rd, 32'h10);
    wb(1'b1, LRC_SHARED_OFS, 32'hd5, 4'hf);
    chk(32'(ctl), 32'hd5);
    chk(32'(port_f_pin5_direction_o), 32'h1);
    chk(32'(timer4_period_o), 32'h12);
    repeat (LRC_SETTLE_CYCLES) @(posedge clk_i);
    chk(32'(lvl), 32'h27);
    wb(1'b0, LRC_SHARED_OFS, 32'h0, 4'hf);
    chk(rd, 32'hd5);
    wb(1'b0, LRC_STATUS_OFS, 32'h0, 4'hf);
    chk(rd, 32'h3);
    wb(1'b1, LRC_SHARED_OFS, 32'h0, 4'he);
    chk(32'(ctl), 32'hd5);
    wb(1'b1, LRC_SHARED_OFS, 32'haa, 4'hf);
    chk(32'(ctl), 32'haa);
    chk(32'(port_f_pin5_direction_o), 32'h0);
    port_f_direction_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'(port_f_pin5_direction_o), 32'h1);
    port_f_direction_i <= 1'b0;
    repeat (LRC_SETTLE_CYCLES) @(posedge clk_i);
    chk(32'(lvl), 32'h28);
    wb(1'b1, LRC_SHARED_OFS, 32'h2a, 4'hf);
    chk(32'(lvl), 32'h0);
    repeat (LRC_SLEEP_CYCLES) @(posedge clk_i);
    chk(32'(ctl), 32'h2a);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(ctl), 32'h0);
    chk(32'(timer4_period_o), 32'(LRC_PERIOD_RST));
    wb(1'b0, LRC_SHARED_OFS, 32'h0, 4'hf);
    chk(rd, 32'(LRC_PERIOD_RST));
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : lrc_ladder_reference_control_tb_top
